// file: core/mac_mode_and_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_flags_params.svh"

module mac_mode_and_status_flags
  import mac_flags_pkg::*;
#(
  parameter int ACC_W = 32,
  parameter int OVR_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Result from the engine datapath
  input wire logic op_done,
  input wire logic [OVR_W-1:0] ovr_prev,
  input wire logic [OVR_W-1:0] ovr_new,
  input wire logic [ACC_W-1:0] acc_new,
  // Controls to the engine datapath
  output logic fractional_select,
  output logic operation_select,
  output logic round_saturate_enable,
  output logic round_saturate,
  output logic accumulator_clear
);

  sfr_byte_t mac_configuration;
  sfr_byte_t mac_status_flags;
  logic clear_pending;
  logic zero_now;
  logic negative_now;
  logic soft_ovf_now;
  logic hard_cross;
  logic wr_cfg;
  logic wr_sta;
  logic hard_event;
  sfr_byte_t next_status;

  assign wr_cfg = sfr_wr && (sfr_addr == `MAC_CONFIG_ADDR);
  assign wr_sta = sfr_wr && (sfr_addr == `MAC_STATUS_ADDR);

  // Pure flag evaluation of the finished result
  mac_flag_eval #(
    .ACC_W(ACC_W),
    .OVR_W(OVR_W)
  ) u_eval (
    .ovr_prev(ovr_prev),
    .ovr_new(ovr_new),
    .acc_new(acc_new),
    .zero_now(zero_now),
    .negative_now(negative_now),
    .soft_ovf_now(soft_ovf_now),
    .hard_cross(hard_cross)
  );

  // Hard overflow counts only while accumulating
  assign hard_event = op_done && !operation_select && hard_cross;

  // Configuration bits; the clear bit is held for one cycle only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fractional_select <= 1'b0;
      operation_select <= 1'b0;
      round_saturate_enable <= 1'b0;
    end else if (wr_cfg) begin
      fractional_select <= sfr_wdata[`CFG_FRAC_SELECT_BIT];
      operation_select <= sfr_wdata[`CFG_OP_SELECT_BIT];
      round_saturate_enable <= sfr_wdata[`CFG_ROUND_SAT_BIT];
    end
  end

  // Clear request lives one cycle, then hardware drops it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      clear_pending <= 1'b0;
    end else begin
      clear_pending <= wr_cfg && sfr_wdata[`CFG_ACC_CLEAR_BIT];
    end
  end

  // Strobe to the accumulator; the saturation bit has no path here
  assign accumulator_clear = clear_pending;

  // Saturation goes to the rounding register only
  assign round_saturate = round_saturate_enable && mac_status_flags[`STA_SOFT_OVF_BIT];

  always_comb begin
    mac_configuration = 8'h00;
    mac_configuration[`CFG_OP_SELECT_BIT] = operation_select;
    mac_configuration[`CFG_FRAC_SELECT_BIT] = fractional_select;
    mac_configuration[`CFG_ROUND_SAT_BIT] = round_saturate_enable;
    mac_configuration[`CFG_ACC_CLEAR_BIT] = clear_pending;
  end

  // Status next value: clear, then software write, then the result wins
  always_comb begin
    next_status = mac_status_flags;
    if (clear_pending) begin
      next_status = `MAC_STATUS_RESET;
    end else if (wr_sta) begin
      next_status = {4'h0, sfr_wdata[3:0]};
    end
    if (op_done) begin
      next_status[`STA_ZERO_BIT] = zero_now;
      next_status[`STA_NEGATIVE_BIT] = negative_now;
      next_status[`STA_SOFT_OVF_BIT] = soft_ovf_now;
    end
    // Event beats any clear landing in the same cycle
    if (hard_event) begin
      next_status[`STA_HARD_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mac_status_flags <= `MAC_STATUS_RESET;
    end else begin
      mac_status_flags <= next_status;
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == `MAC_STATUS_ADDR) begin
        sfr_rdata <= mac_status_flags;
      end else if (sfr_addr == `MAC_CONFIG_ADDR) begin
        sfr_rdata <= mac_configuration;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // Checked from the cause; restating the gate expression would prove nothing
  a_sat_gate: assert property (
    op_done && !wr_cfg && round_saturate_enable && (ovr_new != {OVR_W{acc_new[ACC_W-1]}})
    |=> round_saturate)
    else $error("rounding saturation missing after soft overflow");

  a_clear_isolated: assert property (
    accumulator_clear |-> $past(wr_cfg && sfr_wdata[`CFG_ACC_CLEAR_BIT]))
    else $error("accumulator clear without a clear write");

  a_frac_follow: assert property (
    wr_cfg |=> fractional_select == $past(sfr_wdata[`CFG_FRAC_SELECT_BIT]))
    else $error("fractional select did not take written value");

  a_op_follow: assert property (
    wr_cfg |=> operation_select == $past(sfr_wdata[`CFG_OP_SELECT_BIT]))
    else $error("operation select did not take written value");

  a_hard_set: assert property (
    op_done && !operation_select && (ovr_prev == `OVR_POS_LIMIT) && (ovr_new == `OVR_NEG_LIMIT)
    |=> mac_status_flags[`STA_HARD_OVF_BIT])
    else $error("hard overflow not set on crossing");

  a_hard_reverse: assert property (
    op_done && !operation_select && (ovr_prev == `OVR_NEG_LIMIT) && (ovr_new == `OVR_POS_LIMIT)
    |=> mac_status_flags[`STA_HARD_OVF_BIT])
    else $error("hard overflow not set on reverse crossing");

  a_hard_sticky: assert property (
    mac_status_flags[`STA_HARD_OVF_BIT] && !clear_pending && !wr_sta
    |=> mac_status_flags[`STA_HARD_OVF_BIT])
    else $error("hard overflow dropped by hardware");

  // Software write lands whole in the low nibble; the upper nibble stays zero
  a_status_write: assert property (
    wr_sta && !clear_pending && !op_done
    |=> mac_status_flags == {4'h0, $past(sfr_wdata[3:0])})
    else $error("status write did not land");

  a_zero_track: assert property (
    op_done |=> mac_status_flags[`STA_ZERO_BIT] == ($past(acc_new) == '0))
    else $error("zero flag does not match accumulator");

  a_soft_set: assert property (
    op_done && (ovr_new != {OVR_W{acc_new[ACC_W-1]}}) |=> mac_status_flags[`STA_SOFT_OVF_BIT])
    else $error("soft overflow not set");

  a_soft_clear: assert property (
    op_done && (ovr_new == {OVR_W{acc_new[ACC_W-1]}}) |=> !mac_status_flags[`STA_SOFT_OVF_BIT])
    else $error("soft overflow not cleared");

  a_neg_track: assert property (
    op_done |=> mac_status_flags[`STA_NEGATIVE_BIT] == $past(ovr_new[OVR_W-1]))
    else $error("negative flag does not match result sign");

  // A second clear write right behind the first may legally keep the strobe up
  a_clear_seq: assert property (
    wr_cfg && sfr_wdata[`CFG_ACC_CLEAR_BIT]
    |=> accumulator_clear
    ##1 (($past(wr_cfg && sfr_wdata[`CFG_ACC_CLEAR_BIT]) || !accumulator_clear)
    && ($past(op_done) || (mac_status_flags == `MAC_STATUS_RESET))))
    else $error("clear did not pulse once and reset status");

  c_clear: cover property (wr_cfg && sfr_wdata[`CFG_ACC_CLEAR_BIT] ##2 !accumulator_clear);
  c_hard_ovf: cover property (hard_event);
  c_soft_then_ok: cover property (op_done && soft_ovf_now ##[1:20] op_done && !soft_ovf_now);
  c_saturate: cover property (round_saturate);

endmodule
`default_nettype wire

// file: core/mac_flags_params.svh
`ifndef MAC_FLAGS_PARAMS_SVH
`define MAC_FLAGS_PARAMS_SVH

// Register addresses on the special function register port
`define MAC_STATUS_ADDR 8'hc0
`define MAC_CONFIG_ADDR 8'hc1

// Reset values
`define MAC_STATUS_RESET 8'h04
`define MAC_CONFIG_RESET 8'h00

// Configuration field positions
`define CFG_OP_SELECT_BIT 0
`define CFG_FRAC_SELECT_BIT 1
`define CFG_ROUND_SAT_BIT 2
`define CFG_ACC_CLEAR_BIT 3

// Status field positions
`define STA_NEGATIVE_BIT 0
`define STA_SOFT_OVF_BIT 1
`define STA_ZERO_BIT 2
`define STA_HARD_OVF_BIT 3

// Overflow byte crossing points
`define OVR_POS_LIMIT 8'h7f
`define OVR_NEG_LIMIT 8'h80

`endif

// file: core/mac_flags_pkg.sv
package mac_flags_pkg;

  // One special function register byte
  typedef logic [7:0] sfr_byte_t;

  // Arithmetic format of the engine
  typedef enum logic {
    ARITH_INTEGER,
    ARITH_FRACTIONAL
  } arith_mode_t;

  // Accumulate or multiply only
  typedef enum logic {
    OP_MULT_ACC,
    OP_MULT_ONLY
  } op_mode_t;

endpackage

// file: core/mac_flag_eval.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_flags_params.svh"

module mac_flag_eval
  import mac_flags_pkg::*;
#(
  parameter int ACC_W = 32,
  parameter int OVR_W = 8
) (
  // Result of the finished operation
  input wire logic [OVR_W-1:0] ovr_prev,
  input wire logic [OVR_W-1:0] ovr_new,
  input wire logic [ACC_W-1:0] acc_new,
  // Evaluated flags
  output logic zero_now,
  output logic negative_now,
  output logic soft_ovf_now,
  output logic hard_cross
);

  // Full extended value is negative when the overflow byte is negative
  assign zero_now = (acc_new == '0);
  assign negative_now = ovr_new[OVR_W-1];

  // Some bit of the overflow byte disagrees with the accumulator sign bit
  assign soft_ovf_now = (ovr_new != {OVR_W{acc_new[ACC_W-1]}});

  // Overflow out of the overflow byte, either direction
  always_comb begin
    hard_cross = 1'b0;
    if ((ovr_prev == `OVR_POS_LIMIT) && (ovr_new == `OVR_NEG_LIMIT)) begin
      hard_cross = 1'b1;
    end else if ((ovr_prev == `OVR_NEG_LIMIT) && (ovr_new == `OVR_POS_LIMIT)) begin
      hard_cross = 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: test/mac_mode_and_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_flags_params.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module mac_mode_and_status_flags_tb
  import mac_flags_pkg::*;
();
  // One engine result: config, overflow bytes, accumulator, expected status
  typedef struct packed {
    sfr_byte_t cfg;
    logic [7:0] prev;
    logic [7:0] nw;
    logic [31:0] acc;
    sfr_byte_t sta;
  } row_t;

  logic core_clk;
  logic arst_n;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic op_done;
  logic [7:0] ovr_prev;
  logic [7:0] ovr_new;
  logic [31:0] acc_new;
  logic fractional_select;
  logic operation_select;
  logic round_saturate_enable;
  logic round_saturate;
  logic accumulator_clear;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  row_t rows[8];

  mac_mode_and_status_flags i_mac_mode_and_status_flags (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .op_done(op_done),
    .ovr_prev(ovr_prev),
    .ovr_new(ovr_new),
    .acc_new(acc_new),
    .fractional_select(fractional_select),
    .operation_select(operation_select),
    .round_saturate_enable(round_saturate_enable),
    .round_saturate(round_saturate),
    .accumulator_clear(accumulator_clear)
  );

  // Clock, 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic stop_test;
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Hang guard, far above the roughly 85 cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end

  // Tasks wait for the next edge, drive 1 ns after it and leave 1 ns after the edge that follows
  task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
    @(posedge core_clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge core_clk);
    #1 sfr_wr = 1'b0;
  endtask

  task automatic rd(input sfr_byte_t a);
    @(posedge core_clk);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge core_clk);
    #1 sfr_rd = 1'b0;
  endtask

  task automatic run_op(input row_t r);
    // Configuration only changes while the engine is idle
    wr(`MAC_CONFIG_ADDR, r.cfg);
    `CHK({round_saturate_enable, fractional_select, operation_select}, r.cfg[2:0])
    {ovr_prev, ovr_new, acc_new} = {r.prev, r.nw, r.acc};
    op_done = 1'b1;
    @(posedge core_clk);
    #1 op_done = 1'b0;
    `CHK(round_saturate, r.cfg[2] & r.sta[1])
    rd(`MAC_STATUS_ADDR);
    `CHK(sfr_rdata, r.sta)
  endtask

  initial begin
    {arst_n, sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = '0;
    {op_done, ovr_prev, ovr_new, acc_new} = '0;
    // Status flags end up as {hard, zero, soft, negative}
    rows = '{'{8'h00, 8'h00, 8'h00, 32'h0000_0005, 8'h00},
             '{8'h02, 8'h00, 8'h00, 32'h0000_0000, 8'h04},
             '{8'h02, 8'hff, 8'hff, 32'hffff_fff0, 8'h01},
             '{8'h00, 8'h00, 8'h00, 32'h8000_0000, 8'h02},
             '{8'h00, 8'h00, 8'h00, 32'h0000_0001, 8'h00},
             '{8'h01, 8'h7f, 8'h80, 32'h0000_0000, 8'h07},
             '{8'h04, 8'h80, 8'h7f, 32'h0000_0001, 8'h0a},
             '{8'h00, 8'h00, 8'h00, 32'h0000_0001, 8'h08}};
    repeat (16) @(posedge core_clk);
    `CHK({sfr_rdata, accumulator_clear, round_saturate}, 10'h000)
    #1 arst_n = 1'b1;
    rd(`MAC_STATUS_ADDR);
    `CHK(sfr_rdata, `MAC_STATUS_RESET)
    rd(`MAC_CONFIG_ADDR);
    `CHK(sfr_rdata, `MAC_CONFIG_RESET)
    foreach (rows[i]) run_op(rows[i]);
    // Hard flag stays until software writes zero
    wr(`MAC_STATUS_ADDR, 8'h00);
    rd(`MAC_STATUS_ADDR);
    `CHK(sfr_rdata, 8'h00)
    // Upper status bits refuse writes
    wr(`MAC_STATUS_ADDR, 8'hf5);
    rd(`MAC_STATUS_ADDR);
    `CHK(sfr_rdata, 8'h05)
    run_op('{8'h00, 8'h7f, 8'h80, 32'h0000_0000, 8'h0f});
    // Clear strobe lasts one cycle and resets all flags, hard included
    wr(`MAC_CONFIG_ADDR, 8'h08);
    `CHK(accumulator_clear, 1'b1)
    @(posedge core_clk);
    #1 `CHK(accumulator_clear, 1'b0)
    rd(`MAC_STATUS_ADDR);
    `CHK(sfr_rdata, `MAC_STATUS_RESET)
    // Clear bit and upper bits never read back once the strobe is gone
    wr(`MAC_CONFIG_ADDR, 8'hf7);
    rd(`MAC_CONFIG_ADDR);
    `CHK(sfr_rdata, 8'h07)
    rd(8'hc5);
    `CHK(sfr_rdata, 8'h00)
    stop_test();
  end
endmodule

`default_nettype wire
